// ---- otf_host.sv ----
// Purpose: Host-side model that configures the block over Avalon-MM
// Assumes: One clock, one wait state or more per access
// Notes:   Holds the pull-up of the open-drain regulation ok pin
`timescale 1ns/100ps

module otf_host (
	input  wire logic        clock,
	output logic [4:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	output logic [3:0]       avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	input  wire logic        rok_o,
	input  wire logic        rok_oe,
	output logic             rok_wire
);
	// Pull-up wins whenever the pin is released
	assign rok_wire = rok_oe ? rok_o : 1'b1;

	// Idle bus at time zero
	initial begin
		avs_address    = 5'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hF;
	end

	// Write held until waitrequest is seen low at an edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		avs_write     <= 1'b0;
		avs_writedata <= ~d; // Stale data never lingers
	endtask

	// Read data taken at the completing edge only
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
endmodule

// ---- otf_pkg.sv ----
// Purpose: Types shared by the over-temperature block
// Assumes: Nothing beyond the register header
// Notes:   Response codes match the values software writes
package otf_pkg;

	// Selectable fault responses
	typedef enum logic [2:0] {
		OTF_RESP_IGNORE = 3'h1,
		OTF_RESP_DELAY  = 3'h2,
		OTF_RESP_LATCH  = 3'h3,
		OTF_RESP_AUTO   = 3'h4
	} otf_resp_t;

	// Output control states
	typedef enum logic [1:0] {
		OTF_RUN   = 2'b00,
		OTF_WAIT  = 2'b01,
		OTF_LATCH = 2'b10,
		OTF_AUTO  = 2'b11
	} otf_st_t;

endpackage

// ---- otf_regs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Temperatures are unsigned sensor codes, 12 bits wide
`ifndef OTF_REGS_SVH
`define OTF_REGS_SVH

// Register byte offsets
`define OTF_REG_CTRL    5'h00
`define OTF_REG_FLT     5'h04
`define OTF_REG_WARN    5'h08
`define OTF_REG_RESP    5'h0C
`define OTF_REG_DLY     5'h10
`define OTF_REG_STAT    5'h14
`define OTF_REG_MASK    5'h18
`define OTF_REG_STATE   5'h1C

// Field positions
`define OTF_CTRL_EN     0
`define OTF_CTRL_CLR    1
`define OTF_EV_FAULT    0
`define OTF_EV_SHUT     1
`define OTF_EV_HARD     2

// Reset values
`define OTF_FLT_RST     12'h078
`define OTF_WARN_RST    12'h064
`define OTF_DLY_RST     16'h000A
`define OTF_MASK_RST    3'h0
`define OTF_CTRL_EN_RST 1'b1

// Fixed hard shutdown trip and release points
`define OTF_HARD_TRIP   12'h08C
`define OTF_HARD_REL    12'h07D

// Strap decoding
`define OTF_ADDR_BASE   7'h40
`define OTF_LVL_TRACK   4'h0

// Timing
`define OTF_CLK_MHZ     25
`define OTF_TICK_US     1000
`define OTF_SETTLE_US   10
`define OTF_SETTLE_CYC  (`OTF_SETTLE_US * `OTF_CLK_MHZ)

`endif

// ---- otf_top.sv ----
// Purpose: Over-temperature fault response with Avalon-MM registers
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   One wait state on every bus access
//
// What this block does
// - Evaluate every temperature sample against limit
// - Above limit declares fault, runs selected response
// - Response 1 flags fault, output keeps running
// - Response 2 waits delay, then shuts if persisting
// - Response 3 latches off until clear or re-enable
// - Response 4 off while fault, auto restart
// - Reset selects response 4
// - Fault clears only at or below warn level
// - Host rewrites limit, hysteresis and response
// - Fixed hard thermal shutdown always active
// - Open-drain regulation ok only when ready
// - Bus address taken from address straps
// - Output-level strap picks level or tracking
`timescale 1ns/100ps
`include "otf_regs.svh"

module otf_top #(
	parameter int unsigned TICK_CYC = `OTF_TICK_US * `OTF_CLK_MHZ
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [11:0] temp_sample,
	input  wire logic        temp_valid,
	input  wire logic        remote_enable,
	input  wire logic [2:0]  bus_address_strap_low,
	input  wire logic [2:0]  bus_address_strap_high,
	input  wire logic [3:0]  output_level_strap,
	output logic             output_on,
	output logic             regulation_ok_output_o,
	output logic             regulation_ok_output_oe,
	output logic [6:0]       bus_address,
	output logic             tracking_mode,
	output logic [3:0]       vout_level,
	output logic             irq
);

	typedef struct packed {
		otf_pkg::otf_st_t   st;
		otf_pkg::otf_resp_t resp;
		logic        fault;
		logic        hard;
		logic        out_on;
		logic [15:0] dly_cnt;
		logic [15:0] dly_lim;
		logic [14:0] tick_cnt;
		logic        en_prev;
		logic [7:0]  settle;
		logic        rok_o;
		logic        rok_oe;
		logic        wreq;
		logic [31:0] rdata;
		logic [11:0] flt_lim;
		logic [11:0] warn_lim;
		logic        ctrl_en;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic        irq;
		logic        strap_done;
		logic [6:0]  addr;
		logic        trk;
		logic [3:0]  vlev;
	} otf_state_t;

	otf_state_t st_ff;
	otf_state_t nxt_st;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] be_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic        req;
	logic        done;
	logic        wr_done;
	logic        clr_pulse;
	logic        en;
	logic        en_fall;
	logic        tick;
	logic [31:0] rd_mux;
	logic [31:0] wm;
	logic [31:0] mg;
	logic [2:0]  ev;

	// Bus handshake: one wait cycle, completion when waitrequest low
	assign req     = avs_read | avs_write;
	assign done    = req & ~st_ff.wreq;
	assign wr_done = done & avs_write;
	// Combined enable; a falling edge also releases a latched shutdown
	assign en      = st_ff.ctrl_en & remote_enable;
	assign en_fall = st_ff.en_prev & ~en;
	assign tick    = (st_ff.tick_cnt == 15'(TICK_CYC - 1));

	// Read mux, registered while waitrequest is still high
	always_comb begin
		case (avs_address)
			`OTF_REG_CTRL:  rd_mux = {31'h0, st_ff.ctrl_en};
			`OTF_REG_FLT:   rd_mux = {20'h0, st_ff.flt_lim};
			`OTF_REG_WARN:  rd_mux = {20'h0, st_ff.warn_lim};
			`OTF_REG_RESP:  rd_mux = {29'h0, st_ff.resp};
			`OTF_REG_DLY:   rd_mux = {16'h0, st_ff.dly_lim};
			`OTF_REG_STAT:  rd_mux = {29'h0, st_ff.status};
			`OTF_REG_MASK:  rd_mux = {29'h0, st_ff.mask};
			`OTF_REG_STATE: rd_mux = {15'h0, st_ff.addr, st_ff.vlev, st_ff.trk,
			                          st_ff.st, st_ff.hard, st_ff.fault, st_ff.out_on};
			default:        rd_mux = 32'h0;
		endcase
	end

	assign wm        = be_merge(32'h0, avs_writedata, avs_byteenable);
	assign mg        = be_merge(rd_mux, avs_writedata, avs_byteenable); // Old word from the read mux
	assign clr_pulse = wr_done & (avs_address == `OTF_REG_CTRL)
	                 & avs_byteenable[0] & avs_writedata[`OTF_CTRL_CLR];

	// Next-state logic for the whole block
	always_comb begin
		nxt_st = st_ff;
		ev     = 3'h0;

		// Bus slave
		nxt_st.wreq = ~(req & st_ff.wreq);
		if (req & st_ff.wreq) begin
			nxt_st.rdata = rd_mux;
		end
		if (wr_done) begin
			case (avs_address)
				`OTF_REG_CTRL: begin
					if (avs_byteenable[0]) begin
						nxt_st.ctrl_en = avs_writedata[`OTF_CTRL_EN];
					end
				end
				`OTF_REG_FLT:  nxt_st.flt_lim = mg[11:0];
				`OTF_REG_WARN: nxt_st.warn_lim = mg[11:0];
				`OTF_REG_RESP: begin
					// Out-of-range codes are ignored to keep a valid response
					if (avs_byteenable[0] && wm[2:0] >= 3'h1 && wm[2:0] <= 3'h4) begin
						nxt_st.resp = otf_pkg::otf_resp_t'(wm[2:0]);
					end
				end
				`OTF_REG_DLY:  nxt_st.dly_lim = mg[15:0];
				`OTF_REG_MASK: begin
					if (avs_byteenable[0]) begin
						nxt_st.mask = wm[2:0];
					end
				end
				default: ;
			endcase
		end

		// Millisecond tick for the delayed response
		nxt_st.tick_cnt = tick ? 15'h0000 : st_ff.tick_cnt + 15'h0001;
		nxt_st.en_prev  = en;

		// Sample evaluation with hysteresis
		if (temp_valid) begin
			if (temp_sample > st_ff.flt_lim) begin
				nxt_st.fault = 1'b1;
			end else if (temp_sample <= st_ff.warn_lim) begin
				nxt_st.fault = 1'b0;
			end
			if (temp_sample > `OTF_HARD_TRIP) begin
				nxt_st.hard = 1'b1;
			end else if (temp_sample <= `OTF_HARD_REL) begin
				nxt_st.hard = 1'b0;
			end
		end

		// Response state machine
		case (st_ff.st)
			otf_pkg::OTF_RUN: begin
				if (st_ff.fault) begin
					case (st_ff.resp)
						otf_pkg::OTF_RESP_DELAY: begin
							nxt_st.st      = otf_pkg::OTF_WAIT;
							nxt_st.dly_cnt = 16'h0000;
						end
						otf_pkg::OTF_RESP_LATCH: nxt_st.st = otf_pkg::OTF_LATCH;
						otf_pkg::OTF_RESP_AUTO:  nxt_st.st = otf_pkg::OTF_AUTO;
						default: ;
					endcase
				end
			end
			otf_pkg::OTF_WAIT: begin
				// Shut only if the fault outlives the delay
				if (!st_ff.fault) begin
					nxt_st.st = otf_pkg::OTF_RUN;
				end else if (st_ff.dly_cnt >= st_ff.dly_lim) begin
					nxt_st.st = otf_pkg::OTF_LATCH;
				end else if (tick) begin
					nxt_st.dly_cnt = st_ff.dly_cnt + 16'h0001;
				end
			end
			otf_pkg::OTF_LATCH: begin
				if (clr_pulse || en_fall) begin
					nxt_st.st = otf_pkg::OTF_RUN;
				end
			end
			otf_pkg::OTF_AUTO: begin
				if (!st_ff.fault) begin
					nxt_st.st = otf_pkg::OTF_RUN;
				end
			end
			default: nxt_st.st = otf_pkg::OTF_RUN;
		endcase

		// Output drive follows the next state so status and pin agree
		nxt_st.out_on = en & ~nxt_st.hard & ((nxt_st.st == otf_pkg::OTF_RUN)
		              | (nxt_st.st == otf_pkg::OTF_WAIT));

		// Ready after a short settle; open drain pulls low otherwise
		if (!nxt_st.out_on) begin
			nxt_st.settle = 8'h00;
		end else if (st_ff.settle != 8'(`OTF_SETTLE_CYC)) begin
			nxt_st.settle = st_ff.settle + 8'h01;
		end
		nxt_st.rok_o  = 1'b0;
		nxt_st.rok_oe = ~(nxt_st.out_on & (nxt_st.settle == 8'(`OTF_SETTLE_CYC)));

		// Sticky events; set wins over the read clear
		ev[`OTF_EV_FAULT] = nxt_st.fault & ~st_ff.fault;
		ev[`OTF_EV_SHUT]  = st_ff.out_on & ~nxt_st.out_on;
		ev[`OTF_EV_HARD]  = nxt_st.hard & ~st_ff.hard;
		if (done && avs_read && avs_address == `OTF_REG_STAT) begin
			nxt_st.status = ev;
		end else begin
			nxt_st.status = st_ff.status | ev;
		end
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);

		// Straps caught once, in the first cycle after reset release
		if (!st_ff.strap_done) begin
			nxt_st.strap_done = 1'b1;
			nxt_st.addr = `OTF_ADDR_BASE | {1'b0, bus_address_strap_high,
			                               bus_address_strap_low};
			nxt_st.trk  = (output_level_strap == `OTF_LVL_TRACK);
			nxt_st.vlev = output_level_strap;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= '{
				st:         otf_pkg::OTF_RUN,
				resp:       otf_pkg::OTF_RESP_AUTO,
				fault:      1'b0,
				hard:       1'b0,
				out_on:     1'b0,
				dly_cnt:    16'h0000,
				dly_lim:    `OTF_DLY_RST,
				tick_cnt:   15'h0000,
				en_prev:    1'b0,
				settle:     8'h00,
				rok_o:      1'b0,
				rok_oe:     1'b1,
				wreq:       1'b1,
				rdata:      32'h0,
				flt_lim:    `OTF_FLT_RST,
				warn_lim:   `OTF_WARN_RST,
				ctrl_en:    `OTF_CTRL_EN_RST,
				status:     3'h0,
				mask:       `OTF_MASK_RST,
				irq:        1'b0,
				strap_done: 1'b0,
				addr:       7'h00,
				trk:        1'b0,
				vlev:       4'h0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign avs_readdata            = st_ff.rdata;
	assign avs_waitrequest         = st_ff.wreq;
	assign output_on               = st_ff.out_on;
	assign regulation_ok_output_o  = st_ff.rok_o;
	assign regulation_ok_output_oe = st_ff.rok_oe;
	assign bus_address             = st_ff.addr;
	assign tracking_mode           = st_ff.trk;
	assign vout_level              = st_ff.vlev;
	assign irq                     = st_ff.irq;

	// Checks
	sequence s_hot;
		temp_valid && temp_sample > st_ff.flt_lim;
	endsequence

	sequence s_wait_expire;
		st_ff.st == otf_pkg::OTF_WAIT && st_ff.fault && st_ff.dly_cnt >= st_ff.dly_lim;
	endsequence

	property p_fault_set;
		@(posedge clock) disable iff (rst) s_hot |=> st_ff.fault;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not set");

	property p_hyst;
		@(posedge clock) disable iff (rst)
		st_ff.fault && temp_valid && temp_sample > st_ff.warn_lim |=> st_ff.fault;
	endproperty
	a_hyst: assert property (p_hyst) else $error("fault dropped early");

	property p_ignore;
		@(posedge clock) disable iff (rst)
		st_ff.st == otf_pkg::OTF_RUN && st_ff.resp == otf_pkg::OTF_RESP_IGNORE
		|=> st_ff.st == otf_pkg::OTF_RUN;
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignore shut output");

	property p_delay_cancel;
		@(posedge clock) disable iff (rst)
		st_ff.st == otf_pkg::OTF_WAIT && !st_ff.fault |=> st_ff.st == otf_pkg::OTF_RUN;
	endproperty
	a_delay_cancel: assert property (p_delay_cancel) else $error("delay not cancelled");

	property p_delay_shut;
		@(posedge clock) disable iff (rst) s_wait_expire |=> !st_ff.out_on;
	endproperty
	a_delay_shut: assert property (p_delay_shut) else $error("delay expiry kept output");

	property p_latch_hold;
		@(posedge clock) disable iff (rst)
		st_ff.st == otf_pkg::OTF_LATCH && !clr_pulse && !en_fall
		|=> st_ff.st == otf_pkg::OTF_LATCH && !st_ff.out_on;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch released");

	property p_auto;
		@(posedge clock) disable iff (rst)
		st_ff.st == otf_pkg::OTF_AUTO && !st_ff.fault |=> st_ff.st == otf_pkg::OTF_RUN;
	endproperty
	a_auto: assert property (p_auto) else $error("no auto restart");

	property p_reset_resp;
		@(posedge clock) disable iff (rst) $past(rst) |-> st_ff.resp == otf_pkg::OTF_RESP_AUTO;
	endproperty
	a_reset_resp: assert property (p_reset_resp) else $error("wrong reset response");

	property p_cfg;
		@(posedge clock) disable iff (rst)
		wr_done && avs_address == `OTF_REG_FLT && avs_byteenable == 4'hF
		|=> st_ff.flt_lim == $past(avs_writedata[11:0]);
	endproperty
	a_cfg: assert property (p_cfg) else $error("limit write lost");

	property p_hard;
		@(posedge clock) disable iff (rst) st_ff.hard |-> !st_ff.out_on;
	endproperty
	a_hard: assert property (p_hard) else $error("output on at hard trip");

	property p_rok;
		@(posedge clock) disable iff (rst)
		!regulation_ok_output_oe |-> st_ff.out_on && st_ff.settle == 8'(`OTF_SETTLE_CYC);
	endproperty
	a_rok: assert property (p_rok) else $error("ok while output off");

	property p_flag;
		@(posedge clock) disable iff (rst)
		!st_ff.fault ##1 st_ff.fault |-> st_ff.status[`OTF_EV_FAULT] ##1 1'b1;
	endproperty
	a_flag: assert property (p_flag) else $error("fault flag missing");

endmodule

// ---- tb_over_temp_fault_response.sv ----
// Purpose: Self-checking bench for the over-temperature response block
// Assumes: Short millisecond tick for a quick run
// Notes:   Responses settle within a few cycles of each sample, except the delayed shut, which waits out the delay ticks
`timescale 1ns/100ps
`include "otf_regs.svh"

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_over_temp_fault_response;
	localparam int unsigned TICK = 10;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [11:0] temp_sample = 12'h000;
	logic        temp_valid = 1'b0;
	logic        remote_enable = 1'b1;
	logic        output_on;
	logic        rok_o;
	logic        rok_oe;
	logic        rok_wire;
	logic [3:0]  lvl_strap = 4'h7;
	logic [6:0]  bus_address;
	logic        tracking_mode;
	logic [3:0]  vout_level;
	logic        irq;
	logic [31:0] rdv;
	int          n_errors = 0;
	int          checks_done = 0;
	logic [4:0]  ra [0:5] = '{`OTF_REG_CTRL, `OTF_REG_FLT, `OTF_REG_WARN, `OTF_REG_RESP, `OTF_REG_DLY, `OTF_REG_MASK};
	logic [31:0] rv [0:5] = '{32'h1, {20'h0, `OTF_FLT_RST}, {20'h0, `OTF_WARN_RST}, 32'h4, {16'h0, `OTF_DLY_RST}, 32'h0};

	// 25 MHz clock
	always #20 clock = ~clock;

	otf_top #(.TICK_CYC(TICK)) i_otf_top (
		.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.temp_sample(temp_sample), .temp_valid(temp_valid), .remote_enable(remote_enable),
		.bus_address_strap_low(3'h2), .bus_address_strap_high(3'h5), .output_level_strap(lvl_strap),
		.output_on(output_on), .regulation_ok_output_o(rok_o), .regulation_ok_output_oe(rok_oe),
		.bus_address(bus_address), .tracking_mode(tracking_mode), .vout_level(vout_level), .irq(irq));

	otf_host i_otf_host (
		.clock(clock), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rok_o(rok_o), .rok_oe(rok_oe), .rok_wire(rok_wire));

	// One temperature sample, then time for the response to land
	task automatic tmp(input logic [11:0] v);
		@(posedge clock);
		temp_sample <= v;
		temp_valid  <= 1'b1;
		@(posedge clock);
		temp_valid  <= 1'b0;
		repeat (5) @(posedge clock);
		#1;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic done_t(input string s);
		$display("test %s done", s);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		results();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		settle(8);
		`CHK(bus_address, 7'h6A)
		`CHK(tracking_mode, 1'b0)
		`CHK(vout_level, 4'h7)
		`CHK(rok_wire, 1'b0)
		for (int i = 0; i < 6; i++) begin
			i_otf_host.rd(ra[i], rdv);
			`CHK(rdv, rv[i])
		end
		settle(260);
		`CHK(rok_wire, 1'b1)
		done_t("reset");

		// Default auto restart, masked then unmasked interrupt
		tmp(12'h079);
		`CHK(output_on, 1'b0)
		`CHK(rok_wire, 1'b0)
		`CHK(irq, 1'b0)
		i_otf_host.wr(`OTF_REG_MASK, 32'h7);
		settle(3);
		`CHK(irq, 1'b1)
		i_otf_host.rd(`OTF_REG_STAT, rdv);
		`CHK(rdv, 32'h3)
		settle(3);
		`CHK(irq, 1'b0)
		tmp(12'h070);
		`CHK(output_on, 1'b0)
		tmp(12'h064);
		`CHK(output_on, 1'b1)
		done_t("auto");

		// Ignore response keeps running but flags
		i_otf_host.wr(`OTF_REG_RESP, 32'h1);
		tmp(12'h079);
		`CHK(output_on, 1'b1)
		i_otf_host.rd(`OTF_REG_STATE, rdv);
		`CHK(rdv & 32'h2, 32'h2)
		tmp(12'h064);
		done_t("ignore");

		// Latched: clear command, then enable cycling
		i_otf_host.wr(`OTF_REG_RESP, 32'h3);
		tmp(12'h079);
		`CHK(output_on, 1'b0)
		tmp(12'h064);
		`CHK(output_on, 1'b0)
		i_otf_host.wr(`OTF_REG_CTRL, 32'h3);
		settle(4);
		`CHK(output_on, 1'b1)
		tmp(12'h079);
		`CHK(output_on, 1'b0)
		tmp(12'h064);
		@(posedge clock);
		remote_enable <= 1'b0;
		settle(3);
		@(posedge clock);
		remote_enable <= 1'b1;
		settle(4);
		`CHK(output_on, 1'b1)
		done_t("latch");

		// Delayed: early clear survives, persistent fault shuts
		i_otf_host.wr(`OTF_REG_DLY, 32'h4);
		i_otf_host.wr(`OTF_REG_RESP, 32'h2);
		tmp(12'h079);
		`CHK(output_on, 1'b1)
		tmp(12'h064);
		settle(60);
		`CHK(output_on, 1'b1)
		tmp(12'h079);
		settle(60);
		`CHK(output_on, 1'b0)
		tmp(12'h064);
		i_otf_host.wr(`OTF_REG_CTRL, 32'h3);
		settle(4);
		`CHK(output_on, 1'b1)
		done_t("delay");

		// New limit and clear level take effect
		i_otf_host.wr(`OTF_REG_RESP, 32'h4);
		i_otf_host.wr(`OTF_REG_FLT, 32'h050);
		i_otf_host.wr(`OTF_REG_WARN, 32'h040);
		i_otf_host.rd(`OTF_REG_FLT, rdv);
		`CHK(rdv, 32'h050)
		tmp(12'h055);
		`CHK(output_on, 1'b0)
		tmp(12'h045);
		`CHK(output_on, 1'b0)
		tmp(12'h040);
		`CHK(output_on, 1'b1)
		done_t("limits");

		// Fixed hard shutdown regardless of configuration
		i_otf_host.wr(`OTF_REG_FLT, 32'hFFF);
		i_otf_host.wr(`OTF_REG_RESP, 32'h1);
		i_otf_host.rd(`OTF_REG_STAT, rdv);
		tmp(12'h08D);
		`CHK(output_on, 1'b0)
		tmp(12'h07E);
		`CHK(output_on, 1'b0)
		tmp(12'h07D);
		`CHK(output_on, 1'b1)
		i_otf_host.rd(`OTF_REG_STAT, rdv);
		`CHK(rdv & 32'h4, 32'h4)
		done_t("hard");

		// Mid-run reset: defaults return and straps are taken again
		@(posedge clock);
		rst       <= 1'b1;
		lvl_strap <= `OTF_LVL_TRACK;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		settle(3);
		`CHK(tracking_mode, 1'b1)
		`CHK(vout_level, 4'h0)
		`CHK(bus_address, 7'h6A)
		i_otf_host.rd(`OTF_REG_RESP, rdv);
		`CHK(rdv, 32'h4)
		done_t("rereset");
		results();
	end
endmodule
